// file: hdl/fle_result_regs.sv
// What this block does
// - Detect one- and two-bit errors per sector, correct one; ignore three or more.
// - Check main area and spare area of each loaded sector separately.
// - Update sector status codes on every load, boot loading included.
// - Codes: 00 none, 01 corrected single, 10 uncorrectable double; never 11.
// - Status word holds eight codes, sector four main at top, sector one spare at bottom.
// - Spare code reflects only spare errors, independent of the main code.
// - Main result gives word index of 256 and lane of 16; top nibble zero.
// - Spare result gives spare word selector and lane of 16.
// - Error positions refresh during boot loading as in normal loads.
// - Status at FF00h, main results odd addresses, spare results even addresses.
// - All result registers read-only and reset to zero.
// - Spare selector 00 for second word, 01 for third; 10 and 11 unused.
// - A failed load sets affected codes to 10.
// - A load aborted by reset leaves codes at 00.
//
// Read-only error-result registers of the flash page loader.
// Assumes all inputs come from loader logic on ref_clk_i; the bus
// request is already synchronous to ref_clk_i.
`timescale 1ns/1ps

module fle_result_regs
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // Loader events
   input wire logic load_start_i,
   input wire logic load_abort_i,
   input fle_pkg::fle_fail_s load_fail_i,
   input fle_pkg::fle_check_s check_i,
   // Register port
   input wire logic [15:0] bus_addr_i,
   input wire logic bus_rd_i,
   input wire logic bus_wr_i,
   output logic [15:0] bus_rdata_o,
   output logic bus_rvalid_o
);

   // ==========================================================
   // Storage
   logic [fle_pkg::CODE_W-1:0] main_code_reg [fle_pkg::NUM_SECTORS];
   logic [fle_pkg::CODE_W-1:0] spare_code_reg [fle_pkg::NUM_SECTORS];
   logic [fle_pkg::SYND_W-1:0] main_pos_reg [fle_pkg::NUM_SECTORS];
   logic [fle_pkg::SEL_W-1:0] spare_sel_reg [fle_pkg::NUM_SPARE_REGS];
   logic [fle_pkg::LANE_W-1:0] spare_lane_reg [fle_pkg::NUM_SPARE_REGS];
   fle_pkg::fle_verdict_s verdict;
   logic [15:0] status_word;
   logic [15:0] rdata_next;

   // ==========================================================
   // Decoder
   fle_syndrome_decode u_decode
   (
      .syndrome_i(check_i.syndrome),
      .parity_err_i(check_i.parity_err),
      .verdict_o(verdict)
   );

   // ==========================================================
   // Per-sector results
   // Priority: abort, then fail, then a check, then the load start.
   // A check in the start cycle wins so a first result is never lost.
   // Boot loading drives the same start and check events.
   for (genvar s = 0; s < fle_pkg::NUM_SECTORS; s++)
   begin : g_sector
      logic hit_main;
      logic hit_spare;
      assign hit_main = check_i.valid && (check_i.sector == 2'(s)) && !check_i.spare;
      assign hit_spare = check_i.valid && (check_i.sector == 2'(s)) && check_i.spare;

      always_ff @(posedge ref_clk_i)
      begin
         if (reset_i)
         begin
            main_code_reg[s] <= fle_pkg::CODE_NONE;
            spare_code_reg[s] <= fle_pkg::CODE_NONE;
         end
         else if (load_abort_i)
         begin
            main_code_reg[s] <= fle_pkg::CODE_NONE;
            spare_code_reg[s] <= fle_pkg::CODE_NONE;
         end
         else if (load_fail_i.valid && load_fail_i.sectors[s])
         begin
            if (load_fail_i.main)
            begin
               main_code_reg[s] <= fle_pkg::CODE_DOUBLE;
            end
            if (load_fail_i.spare)
            begin
               spare_code_reg[s] <= fle_pkg::CODE_DOUBLE;
            end
         end
         else if (hit_main)
         begin
            main_code_reg[s] <= verdict.code;
         end
         else if (hit_spare)
         begin
            spare_code_reg[s] <= verdict.code;
         end
         else if (load_start_i)
         begin
            main_code_reg[s] <= fle_pkg::CODE_NONE;
            spare_code_reg[s] <= fle_pkg::CODE_NONE;
         end
      end

      always_ff @(posedge ref_clk_i)
      begin
         if (reset_i)
         begin
            main_pos_reg[s] <= fle_pkg::RESET_WORD[fle_pkg::SYND_W-1:0];
         end
         else if (hit_main && !load_abort_i)
         begin
            main_pos_reg[s] <= verdict.position;
         end
         else if (load_start_i)
         begin
            main_pos_reg[s] <= fle_pkg::RESET_WORD[fle_pkg::SYND_W-1:0];
         end
      end

      if (s < fle_pkg::NUM_SPARE_REGS)
      begin : g_spare_pos
         always_ff @(posedge ref_clk_i)
         begin
            if (reset_i)
            begin
               spare_sel_reg[s] <= fle_pkg::SEL_WORD2;
               spare_lane_reg[s] <= fle_pkg::RESET_WORD[fle_pkg::LANE_W-1:0];
            end
            else if (hit_spare && !load_abort_i)
            begin
               spare_sel_reg[s] <= verdict.position[fle_pkg::SPARE_WORD_BIT] ?
                                   fle_pkg::SEL_WORD3 : fle_pkg::SEL_WORD2;
               spare_lane_reg[s] <= verdict.position[fle_pkg::LANE_LSB +: fle_pkg::LANE_W];
            end
            else if (load_start_i)
            begin
               spare_sel_reg[s] <= fle_pkg::SEL_WORD2;
               spare_lane_reg[s] <= fle_pkg::RESET_WORD[fle_pkg::LANE_W-1:0];
            end
         end
      end

      assign status_word[s*fle_pkg::STATUS_SECTOR_STRIDE + fle_pkg::STATUS_MAIN_LSB +: fle_pkg::CODE_W]
         = main_code_reg[s];
      assign status_word[s*fle_pkg::STATUS_SECTOR_STRIDE + fle_pkg::STATUS_SPARE_LSB +: fle_pkg::CODE_W]
         = spare_code_reg[s];
   end

   // ==========================================================
   // Read decode
   // Writes are accepted on the bus but change nothing here.
   always_comb
   begin
      rdata_next = fle_pkg::RESET_WORD;
      unique case (bus_addr_i)
         fle_pkg::ADDR_STATUS:   rdata_next = status_word;
         fle_pkg::ADDR_S0_MAIN:  rdata_next[fle_pkg::SYND_W-1:0] = main_pos_reg[0];
         fle_pkg::ADDR_S1_MAIN:  rdata_next[fle_pkg::SYND_W-1:0] = main_pos_reg[1];
         fle_pkg::ADDR_S2_MAIN:  rdata_next[fle_pkg::SYND_W-1:0] = main_pos_reg[2];
         fle_pkg::ADDR_S3_MAIN:  rdata_next[fle_pkg::SYND_W-1:0] = main_pos_reg[3];
         fle_pkg::ADDR_S0_SPARE:
         begin
            rdata_next[fle_pkg::SEL_LSB +: fle_pkg::SEL_W] = spare_sel_reg[0];
            rdata_next[fle_pkg::LANE_LSB +: fle_pkg::LANE_W] = spare_lane_reg[0];
         end
         fle_pkg::ADDR_S1_SPARE:
         begin
            rdata_next[fle_pkg::SEL_LSB +: fle_pkg::SEL_W] = spare_sel_reg[1];
            rdata_next[fle_pkg::LANE_LSB +: fle_pkg::LANE_W] = spare_lane_reg[1];
         end
         fle_pkg::ADDR_S2_SPARE:
         begin
            rdata_next[fle_pkg::SEL_LSB +: fle_pkg::SEL_W] = spare_sel_reg[2];
            rdata_next[fle_pkg::LANE_LSB +: fle_pkg::LANE_W] = spare_lane_reg[2];
         end
         default:                rdata_next = fle_pkg::RESET_WORD;
      endcase
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         bus_rdata_o <= fle_pkg::RESET_WORD;
         bus_rvalid_o <= 1'b0;
      end
      else
      begin
         bus_rvalid_o <= bus_rd_i;
         if (bus_rd_i)
         begin
            bus_rdata_o <= rdata_next;
         end
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);

   logic quiet;
   assign quiet = !load_abort_i && !load_fail_i.valid;

   AST_NO_RESERVED_CODE: assert property (
      !(status_word[15] && status_word[14]) && !(status_word[13] && status_word[12]) &&
      !(status_word[11] && status_word[10]) && !(status_word[9] && status_word[8]) &&
      !(status_word[7] && status_word[6]) && !(status_word[5] && status_word[4]) &&
      !(status_word[3] && status_word[2]) && !(status_word[1] && status_word[0]))
      else $error("Status code 11 produced");

   AST_START_CLEARS: assert property (
      load_start_i && !check_i.valid && quiet |=> status_word == 16'h0000 && main_pos_reg[0] == 12'h000)
      else $error("Load start did not clear results");

   AST_ABORT_ZERO: assert property (
      load_abort_i |=> status_word == 16'h0000)
      else $error("Aborted load left a nonzero code");

   AST_FAIL_MAIN: assert property (
      load_fail_i.valid && !load_abort_i && load_fail_i.main && load_fail_i.sectors[3]
      |=> status_word[15:14] == 2'h2)
      else $error("Failed load did not mark sector four main");

   AST_SINGLE_MAIN: assert property (
      check_i.valid && quiet && !check_i.spare && check_i.sector == 2'h0 && check_i.parity_err
      |=> status_word[3:2] == 2'h1 && main_pos_reg[0] == $past(check_i.syndrome))
      else $error("Single error not reported with its position");

   AST_DOUBLE_SPARE: assert property (
      check_i.valid && quiet && check_i.spare && check_i.sector == 2'h1 &&
      !check_i.parity_err && check_i.syndrome != 12'h000
      |=> status_word[5:4] == 2'h2)
      else $error("Double error in spare not reported");

   AST_SPARE_INDEPENDENT: assert property (
      check_i.valid && quiet && check_i.spare && !load_start_i |=> $stable(status_word[15:14]) &&
      $stable(status_word[11:10]) && $stable(status_word[7:6]) && $stable(status_word[3:2]))
      else $error("Spare check disturbed a main code");

   AST_WRITE_IGNORED: assert property (
      bus_wr_i && !check_i.valid && quiet && !load_start_i |=> $stable(status_word))
      else $error("Bus write altered a result");

   AST_STATUS_READ: assert property (
      bus_rd_i && bus_addr_i == fle_pkg::ADDR_STATUS ##1 bus_rvalid_o |-> bus_rdata_o == $past(status_word))
      else $error("Status read returned wrong data");

   AST_MAIN_TOP_ZERO: assert property (
      bus_rd_i && bus_addr_i == fle_pkg::ADDR_S3_MAIN |=> bus_rvalid_o && bus_rdata_o[15:12] == 4'h0)
      else $error("Main result top nibble not zero");

   AST_SPARE_SEL: assert property (
      bus_rd_i && bus_addr_i == fle_pkg::ADDR_S0_SPARE |=> bus_rdata_o[15:6] == 10'h000 && !bus_rdata_o[5])
      else $error("Spare selector out of range");

   // ==========================================================
   // Bus timing, position and failed-load checks
   // Read data is registered, so the valid pulse trails the request by
   // exactly one edge; a host sampling later would miss the valid pulse, though the data holds.
   AST_RVALID_ON_READ: assert property (
      bus_rd_i |=> bus_rvalid_o)
      else $error("Read not answered one cycle later");

   AST_RVALID_ONE_CYCLE: assert property (
      !bus_rd_i |=> !bus_rvalid_o)
      else $error("Read valid without a read request");

   AST_READ_HOLDS: assert property (
      !bus_rd_i |=> $stable(bus_rdata_o))
      else $error("Read data changed without a read");

   AST_SPARE_WORD_SEL: assert property (
      check_i.valid && quiet && check_i.spare && check_i.sector == 2'h0 && check_i.parity_err
      |=> spare_lane_reg[0] == $past(check_i.syndrome[3:0]) &&
      spare_sel_reg[0] == ($past(check_i.syndrome[fle_pkg::SPARE_WORD_BIT]) ?
      fle_pkg::SEL_WORD3 : fle_pkg::SEL_WORD2))
      else $error("Spare error position not recorded");

   AST_DOUBLE_NO_POSITION: assert property (
      check_i.valid && quiet && !check_i.spare && check_i.sector == 2'h2 &&
      !check_i.parity_err && check_i.syndrome != 12'h000
      |=> status_word[11:10] == 2'h2 && main_pos_reg[2] == 12'h000)
      else $error("Uncorrectable error left a position");

   AST_FAIL_SPARE: assert property (
      load_fail_i.valid && !load_abort_i && load_fail_i.spare && load_fail_i.sectors[0]
      |=> status_word[1:0] == 2'h2)
      else $error("Failed load did not mark sector one spare");

   // Abort clears codes only; the last positions stay readable
   AST_ABORT_KEEPS_POS: assert property (
      load_abort_i && !load_start_i |=> $stable(main_pos_reg[1]) && $stable(spare_lane_reg[1]))
      else $error("Aborted load altered an error position");

   COV_SINGLE: cover property (check_i.valid && check_i.parity_err ##[1:3] bus_rd_i);
   COV_DOUBLE: cover property (check_i.valid && !check_i.parity_err && check_i.syndrome != 12'h000);
   COV_FAIL: cover property (load_fail_i.valid && load_fail_i.main && load_fail_i.spare);
   COV_ABORT: cover property (load_start_i ##[1:20] load_abort_i);
   COV_ABORT_WITH_CHECK: cover property (load_abort_i && check_i.valid);

endmodule : fle_result_regs

// file: hdl/fle_pkg.sv
// Constants, field layouts and carrier types for the load error-result block.
// Assumes a 16-bit register data path and 16-bit word addresses.
package fle_pkg;

   // ==========================================================
   // Register word addresses
   localparam logic [15:0] ADDR_STATUS = 16'hFF00;
   localparam logic [15:0] ADDR_S0_MAIN = 16'hFF01;
   localparam logic [15:0] ADDR_S0_SPARE = 16'hFF02;
   localparam logic [15:0] ADDR_S1_MAIN = 16'hFF03;
   localparam logic [15:0] ADDR_S1_SPARE = 16'hFF04;
   localparam logic [15:0] ADDR_S2_MAIN = 16'hFF05;
   localparam logic [15:0] ADDR_S2_SPARE = 16'hFF06;
   localparam logic [15:0] ADDR_S3_MAIN = 16'hFF07;

   // ==========================================================
   // Reset values
   localparam logic [15:0] RESET_WORD = 16'h0000;

   // ==========================================================
   // Sizes and field positions
   localparam int NUM_SECTORS = 4;
   localparam int NUM_SPARE_REGS = 3;
   localparam int CODE_W = 2;
   localparam int STATUS_MAIN_LSB = 2;
   localparam int STATUS_SPARE_LSB = 0;
   localparam int STATUS_SECTOR_STRIDE = 4;
   localparam int LANE_LSB = 0;
   localparam int LANE_W = 4;
   localparam int WORD_LSB = 4;
   localparam int WORD_W = 8;
   localparam int SEL_LSB = 4;
   localparam int SEL_W = 2;
   localparam int SYND_W = WORD_W + LANE_W;
   // Syndrome bit that splits the second spare word from the third
   localparam int SPARE_WORD_BIT = 4;

   // ==========================================================
   // Status codes and spare word selectors
   localparam logic [1:0] CODE_NONE = 2'h0;
   localparam logic [1:0] CODE_SINGLE = 2'h1;
   localparam logic [1:0] CODE_DOUBLE = 2'h2;
   localparam logic [1:0] SEL_WORD2 = 2'h0;
   localparam logic [1:0] SEL_WORD3 = 2'h1;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic valid;
      logic [1:0] sector;
      logic spare;
      logic [SYND_W-1:0] syndrome;
      logic parity_err;
   } fle_check_s;

   typedef struct packed {
      logic valid;
      logic [NUM_SECTORS-1:0] sectors;
      logic main;
      logic spare;
   } fle_fail_s;

   typedef struct packed {
      logic [1:0] code;
      logic [SYND_W-1:0] position;
   } fle_verdict_s;

endpackage : fle_pkg

// file: hdl/fle_syndrome_decode.sv
// Combinational classifier for one extended-Hamming check result.
// Assumes the syndrome encodes the failing bit position directly.
`timescale 1ns/1ps

module fle_syndrome_decode
(
   // Check result
   input wire logic [fle_pkg::SYND_W-1:0] syndrome_i,
   input wire logic parity_err_i,
   // Verdict
   output fle_pkg::fle_verdict_s verdict_o
);

   // ==========================================================
   // Classification
   // Overall parity odd means one flipped bit; even parity with a
   // nonzero syndrome means two. Three or more alias to one of these
   // and are not handled.
   always_comb
   begin
      verdict_o.position = fle_pkg::RESET_WORD[fle_pkg::SYND_W-1:0];
      if (parity_err_i)
      begin
         verdict_o.code = fle_pkg::CODE_SINGLE;
         verdict_o.position = syndrome_i;
      end
      else if (syndrome_i != '0)
      begin
         verdict_o.code = fle_pkg::CODE_DOUBLE;
      end
      else
      begin
         verdict_o.code = fle_pkg::CODE_NONE;
      end
   end

endmodule : fle_syndrome_decode

// file: verif/fle_host_model.sv
// Host side of the result register port: single-cycle reads and writes.
// Assumes the device answers a read with a one-cycle valid pulse.
`timescale 1ns/1ps

module fle_host_model
(
   // Clock
   input wire logic ref_clk_i,
   // Answer from the device
   input wire logic [15:0] rdata_i,
   input wire logic rvalid_i,
   // Requests to the device
   output logic [15:0] addr_o,
   output logic rd_o,
   output logic wr_o
);
   initial
   begin
      addr_o = 16'h0000;
      rd_o = 1'b0;
      wr_o = 1'b0;
   end

   task automatic read_word(input logic [15:0] addr, output logic [15:0] data);
      int n;
      n = 0;
      data = 'x;
      @(negedge ref_clk_i);
      addr_o = addr;
      rd_o = 1'b1;
      @(negedge ref_clk_i);
      rd_o = 1'b0;
      // Released address shows its inverse so a late sample cannot alias
      addr_o = ~addr;
      while (rvalid_i !== 1'b1 && n < 4)
      begin
         @(negedge ref_clk_i);
         n++;
      end
      if (rvalid_i === 1'b1)
         data = rdata_i;
   endtask : read_word

   // Issued to prove it is ignored; nothing later relies on it
   task automatic write_word(input logic [15:0] addr);
      @(negedge ref_clk_i);
      addr_o = addr;
      wr_o = 1'b1;
      @(negedge ref_clk_i);
      wr_o = 1'b0;
      addr_o = ~addr;
   endtask : write_word
endmodule : fle_host_model

// file: verif/test_flash_load_ecc_result_regs.sv
// Self-checking bench for the load error-result registers.
// Assumes the host model drives the register port and events are bench-driven.
`timescale 1ns/1ps

module test_flash_load_ecc_result_regs;
   logic ref_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic load_start_i = 1'b0;
   logic load_abort_i = 1'b0;
   fle_pkg::fle_fail_s load_fail_i = '0;
   fle_pkg::fle_check_s check_i = '0;
   logic [15:0] bus_addr_i;
   logic bus_rd_i;
   logic bus_wr_i;
   logic [15:0] bus_rdata_o;
   logic bus_rvalid_o;
   int error_cnt = 0;
   int checks_done = 0;
   int cycles = 0;
   int cm[4];
   int cs[4];
   logic [11:0] pm[4];
   logic [11:0] ps[4];

   fle_result_regs u_fle_result_regs (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .load_start_i(load_start_i),
      .load_abort_i(load_abort_i), .load_fail_i(load_fail_i), .check_i(check_i), .bus_addr_i(bus_addr_i),
      .bus_rd_i(bus_rd_i), .bus_wr_i(bus_wr_i), .bus_rdata_o(bus_rdata_o), .bus_rvalid_o(bus_rvalid_o));
   fle_host_model u_fle_host_model (.ref_clk_i(ref_clk_i), .rdata_i(bus_rdata_o), .rvalid_i(bus_rvalid_o),
      .addr_o(bus_addr_i), .rd_o(bus_rd_i), .wr_o(bus_wr_i));

   initial
   begin
      forever #25 ref_clk_i = ~ref_clk_i;
   end

   // Whole run needs about 550 cycles
   always @(posedge ref_clk_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         error_cnt++;
         tally_and_finish();
      end
   end

   // ==========================================================
   // Reference model and comparison
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         $display("Error %s expected %h seen %h", what, exp, seen);
         error_cnt++;
      end
   endtask : check

   task automatic clear_model(input bit codes_only);
      for (int s = 0; s < 4; s++)
      begin
         cm[s] = 0;
         cs[s] = 0;
         if (!codes_only)
         begin
            pm[s] = 12'h000;
            ps[s] = 12'h000;
         end
      end
   endtask : clear_model

   function automatic logic [15:0] expect_reg(input int idx);
      logic [15:0] v;
      int s;
      v = 16'h0000;
      s = (idx - 1) / 2;
      if (idx == 0)
         for (int k = 0; k < 4; k++)
            v[4*k +: 4] = {cm[k][1:0], cs[k][1:0]};
      else if (idx < 8 && idx % 2 == 1)
         v = {4'h0, pm[s]};
      else if (idx < 8)
         v = {10'h000, 1'b0, ps[s][4], ps[s][3:0]};
      return v;
   endfunction : expect_reg

   task automatic check_all();
      logic [15:0] d;
      for (int i = 0; i < 9; i++)
      begin
         u_fle_host_model.read_word(16'hFF00 + 16'(i), d);
         check($sformatf("reg_%0d", i), d, expect_reg(i));
      end
   endtask : check_all

   // ==========================================================
   // Loader event drivers
   task automatic idle();
      @(negedge ref_clk_i);
      load_start_i = 1'b0;
      load_abort_i = 1'b0;
      load_fail_i = '0;
      check_i = '0;
   endtask : idle

   task automatic do_check(input int s, input int sp, input logic [11:0] syn, input int par);
      int code;
      @(negedge ref_clk_i);
      check_i = '{1'b1, 2'(s), sp[0], syn, par[0]};
      code = par[0] ? 1 : (syn != 12'h000 ? 2 : 0);
      if (sp[0])
      begin
         cs[s] = code;
         ps[s] = par[0] ? syn : 12'h000;
      end
      else
      begin
         cm[s] = code;
         pm[s] = par[0] ? syn : 12'h000;
      end
   endtask : do_check

   task automatic do_event(input int kind, input logic [3:0] secs, input bit m, input bit sp);
      @(negedge ref_clk_i);
      case (kind)
         0: load_start_i = 1'b1;
         1: load_abort_i = 1'b1;
         default: load_fail_i = '{1'b1, secs, m, sp};
      endcase
      if (kind < 2)
         clear_model(kind == 1);
      for (int s = 0; s < 4; s++)
         if (kind == 2 && secs[s])
         begin
            cm[s] = m ? 2 : cm[s];
            cs[s] = sp ? 2 : cs[s];
         end
      idle();
   endtask : do_event

   task automatic tally_and_finish();
      $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish

   // ==========================================================
   // Main sequence
   initial
   begin
      void'($urandom(32'h5e83f022));
      clear_model(1'b0);
      repeat (20) @(negedge ref_clk_i);
      reset_i = 1'b0;
      check_all();
      // Random loads, back-to-back checks over all sectors and areas
      repeat (12)
      begin
         do_event(0, 4'h0, 1'b0, 1'b0);
         repeat (6) do_check($urandom_range(3), $urandom_range(1), 12'($urandom), $urandom_range(1));
         idle();
         check_all();
      end
      // Every code on every area
      for (int c = 0; c < 3; c++)
      begin
         for (int s = 0; s < 8; s++)
            do_check(s / 2, s % 2, (c == 0) ? 12'h000 : 12'h3D5 + 12'(s), int'(c == 1));
         idle();
         check_all();
      end
      // Writes must leave every register untouched
      for (int i = 0; i < 9; i++)
         u_fle_host_model.write_word(16'hFF00 + 16'(i));
      check_all();
      do_event(2, 4'hA, 1'b1, 1'b0);
      do_event(2, 4'h5, 1'b0, 1'b1);
      do_event(2, 4'h3, 1'b1, 1'b1);
      check_all();
      // Abort lands while a check is still offered: codes clear, position stays
      do_event(0, 4'h0, 1'b0, 1'b0);
      do_check(1, 0, 12'h5A7, 1);
      do_event(1, 4'h0, 1'b0, 1'b0);
      check_all();
      // Reset in mid-run after a load with errors
      do_check(2, 0, 12'hABC, 1);
      idle();
      reset_i = 1'b1;
      repeat (2) @(negedge ref_clk_i);
      reset_i = 1'b0;
      clear_model(1'b0);
      check("rdata_after_reset", bus_rdata_o, 16'h0000);
      check("rvalid_after_reset", 16'(bus_rvalid_o), 16'h0000);
      check_all();
      tally_and_finish();
   end
endmodule : test_flash_load_ecc_result_regs
